// ### rtl/lock_detect_defines.svh
`ifndef LOCK_DETECT_DEFINES_SVH
`define LOCK_DETECT_DEFINES_SVH

// serial port register addresses
`define ADDR_W              6
`define LKD_CFG_ADDR        6'h07
`define EN_CFG_ADDR         6'h08
`define DATA_W              24

// register widths and reset values
`define LKD_CFG_W           21
`define EN_CFG_W            14
`define LKD_CFG_RST         21'h10_04fa
`define EN_CFG_RST          14'h31ff

// field positions of the lock detect register
`define LKD_WINCNT_LSB      0
`define LKD_WINCNT_W        10
`define LKD_ENABLE_BIT      10
`define LKD_ASYM_BIT        11
`define LKD_LEAD_BIT        12
`define LKD_RING_SEL_BIT    13
`define LKD_DUR_LSB         14
`define LKD_TRIM_LSB        17
`define LKD_FORCE_BIT       19
`define LKD_SLIP_BIT        20

// field positions of the enable register
`define EN_BIAS_BIT         0
`define EN_PUMP_BIT         1
`define EN_PFD_BIT          2
`define EN_REFBUF_BIT       3
`define EN_VCOBUF_BIT       4
`define EN_GPIO_BIT         5
`define EN_READBACK_BIT     6
`define EN_DIGCLK_BIT       7
`define EN_VCODIV_BIT       8
`define EN_DUTY_BIT         10
`define EN_RAW_REF_BIT      12
`define EN_DIV_REF_BIT      13

// timing
`define CLK_PERIOD_NS       10
`define ONESHOT_NS          20
`define ONESHOT_CYC         (`ONESHOT_NS / `CLK_PERIOD_NS)
`define DUTY_RATIO_MIN      32
`define STRETCH_CYC         4
`define RATIO_W             17

`endif

// ### rtl/lock_detect_pkg.sv
package lock_detect_pkg;

  // lock detect and slip prevention fields, msb first
  typedef struct packed {
    logic       slip_prevent_on;
    logic       ring_force_run;
    logic [1:0] ring_trim;
    logic [2:0] ring_duration;
    logic       ring_oneshot_sel;
    logic       lead_window_sel;
    logic       asym_window_on;
    logic       lock_detect_on;
    logic [9:0] lock_count_max;
  } lkd_cfg_s;

  // block power enables, msb first
  typedef struct packed {
    logic divided_ref_feed_on;
    logic raw_ref_feed_on;
    logic spare_b11;
    logic duty_stretch_on;
    logic spare_b9;
    logic vcodiv_on;
    logic vcodiv_digclk_on;
    logic readback_pad_on;
    logic gpio_pads_on;
    logic vco_buf_on;
    logic ref_buf_on;
    logic pfd_on;
    logic pump_on;
    logic bias_on;
  } en_cfg_s;

  // lock window tracker
  typedef enum logic [1:0] {
    WIN_IDLE = 2'b00,
    WIN_OPEN = 2'b01
  } win_state_e;

endpackage : lock_detect_pkg

// ### rtl/lock_oneshot.sv
`timescale 1ns/1ps
`include "lock_detect_defines.svh"

module lock_oneshot
  import lock_detect_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  input  wire logic       start_i,
  input  wire logic       ring_sel_i,
  input  wire logic [2:0] duration_i,
  input  wire logic [1:0] trim_i,
  input  wire logic       force_run_i,
  output logic            window_o,
  output logic            ring_tick_o
);

  logic [1:0] ring_cnt_r;
  logic [3:0] remain_r;
  logic       ring_run;
  logic       ring_wrap;
  logic [3:0] load_val;

  // ring runs only while timing a window or when forced on
  assign ring_run  = force_run_i | (ring_sel_i & (remain_r != 4'h0));
  assign ring_wrap = ring_run & (ring_cnt_r == trim_i);
  assign ring_tick_o = ring_wrap;
  // analog shot is a fixed count, ring shot counts ring periods
  assign load_val = ring_sel_i ? ({1'b0, duration_i} + 4'h1)
                               : 4'(`ONESHOT_CYC);
  assign window_o = (remain_r != 4'h0);

  // ring period: trim 00 wraps every cycle, 11 every fourth
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !ring_run || ring_wrap) begin
      ring_cnt_r <= 2'h0;
    end else begin
      ring_cnt_r <= ring_cnt_r + 2'h1;
    end
  end

  // window countdown, a restart reloads it
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      remain_r <= 4'h0;
    end else if (start_i) begin
      remain_r <= load_val;
    end else if (window_o && (!ring_sel_i || ring_wrap)) begin
      remain_r <= remain_r - 4'h1;
    end
  end

endmodule : lock_oneshot

// ### rtl/vcodiv_stretch.sv
`timescale 1ns/1ps
`include "lock_detect_defines.svh"

module vcodiv_stretch
  import lock_detect_pkg::*;
(
  input  wire logic                ref_clk_i,
  input  wire logic                reset_i,
  input  wire logic                div_pulse_i,
  input  wire logic                div_on_i,
  input  wire logic                stretch_on_i,
  input  wire logic [`RATIO_W-1:0] ratio_i,
  output logic                     div_clk_o
);

  logic [2:0] hold_r;
  logic       long_ratio;

  // stretching only pays off once the ratio leaves room for it
  assign long_ratio = stretch_on_i
                    & (ratio_i > `RATIO_W'(`DUTY_RATIO_MIN));

  // hold count: one cycle plain, several when stretched
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !div_on_i) begin
      hold_r <= 3'h0;
    end else if (div_pulse_i) begin
      hold_r <= long_ratio ? 3'(`STRETCH_CYC) : 3'h1;
    end else if (hold_r != 3'h0) begin
      hold_r <= hold_r - 3'h1;
    end
  end

  // registered so the digital clock feed carries no glitch
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      div_clk_o <= 1'b0;
    end else begin
      div_clk_o <= div_on_i & (div_pulse_i | (hold_r > 3'h1));
    end
  end

endmodule : vcodiv_stretch

// ### rtl/lock_detect_and_enable_regs.sv
`timescale 1ns/1ps
`include "lock_detect_defines.svh"

// How it works
// - lock declared after programmed count of consecutive in-window edges
// - lock detect enable bit, default on, turns lock detection on
// - asymmetric bit restricts window to only lead or only lag
// - lead/lag select picks lead window at 1, lag at 0
// - one-shot select picks ring one-shot at 1, 20 ns analog at 0
// - three-bit field sets ring one-shot pulse length, default zero
// - two-bit trim sets ring speed; separate bit forces ring running
// - bit defaulting on enables cycle slip prevention
// - low enable bits, default on, power bias, pump, pfd, buffers
// - gpio pad enable powers both digital pads
// - readback pad enable lets lock or readback drive that pad
// - two bits enable vco divider and its clock to digital
// - duty mode stretches divider output pulse when ratio exceeds 32
// - raw reference feed to digital when its bit is set
// - divided reference feed to digital when its bit is set
module lock_detect_and_enable_regs
  import lock_detect_pkg::*;
(
  input  wire logic                ref_clk_i,
  input  wire logic                reset_i,
  // completed serial port transfers
  input  wire logic                wr_stb_i,
  input  wire logic [`ADDR_W-1:0]  wr_addr_i,
  input  wire logic [`DATA_W-1:0]  wr_data_i,
  input  wire logic [`ADDR_W-1:0]  rd_addr_i,
  output logic      [`DATA_W-1:0]  rd_data_o,
  // phase detector edges as one-cycle pulses
  input  wire logic                ref_edge_i,
  input  wire logic                vco_edge_i,
  input  wire logic                ref_in_i,
  // vco divider
  input  wire logic                div_pulse_i,
  input  wire logic [`RATIO_W-1:0] div_ratio_i,
  // pad sources
  input  wire logic                lock_output_route_i,
  input  wire logic                readback_active_i,
  input  wire logic                readback_data_i,
  input  wire logic [1:0]          gpo_data_i,
  // results
  output logic                     lock_o,
  output logic                     ring_tick_o,
  output en_cfg_s                  power_en_o,
  output logic                     slip_prevent_on_o,
  output logic                     raw_ref_feed_o,
  output logic                     divided_ref_feed_o,
  output logic                     div_clk_o,
  output logic                     lock_readback_pin_o,
  output logic                     lock_readback_pin_oe_n_o,
  output logic [1:0]               gpio_pad_o,
  output logic [1:0]               gpio_pad_oe_n_o
);

  // register selection, shared by write and read
  function automatic logic [1:0] reg_sel(input logic [`ADDR_W-1:0] a);
    reg_sel = {a == `EN_CFG_ADDR, a == `LKD_CFG_ADDR};
  endfunction : reg_sel

  // written copies and the copies that steer the hardware
  lkd_cfg_s lkd_wr_r;
  en_cfg_s  en_wr_r;
  lkd_cfg_s lkd_r;
  en_cfg_s  en_r;

  logic [1:0] wr_hit;
  logic [1:0] rd_hit;
  logic [`DATA_W-1:0] rd_nxt;

  // ---------------------------------------------------------------
  // register access
  // ---------------------------------------------------------------

  // decode of the serial port address
  assign wr_hit = wr_stb_i ? reg_sel(wr_addr_i) : 2'b00;
  assign rd_hit = reg_sel(rd_addr_i);

  // readback of the written copy; unmapped addresses read zero
  assign rd_nxt = rd_hit[0] ? `DATA_W'(lkd_wr_r) :
                  rd_hit[1] ? `DATA_W'(en_wr_r)  :
                  `DATA_W'(0);

  // whole-word capture, no field ever lands alone
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      lkd_wr_r <= lkd_cfg_s'(`LKD_CFG_RST);
      en_wr_r  <= en_cfg_s'(`EN_CFG_RST);
    end else begin
      if (wr_hit[0]) begin
        lkd_wr_r <= lkd_cfg_s'(wr_data_i[`LKD_CFG_W-1:0]);
      end
      if (wr_hit[1]) begin
        en_wr_r <= en_cfg_s'(wr_data_i[`EN_CFG_W-1:0]);
      end
    end
  end

  // settings move into service only at a reference edge; a window
  // opened by that same edge is loaded under the old settings and timed under the new
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      lkd_r <= lkd_cfg_s'(`LKD_CFG_RST);
      en_r  <= en_cfg_s'(`EN_CFG_RST);
    end else if (ref_edge_i) begin
      lkd_r <= lkd_wr_r;
      en_r  <= en_wr_r;
    end
  end

  // registered read data
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rd_data_o <= `DATA_W'(0);
    end else begin
      rd_data_o <= rd_nxt;
    end
  end

  // ---------------------------------------------------------------
  // lock window timing
  // ---------------------------------------------------------------

  win_state_e  win_r;
  win_state_e  win_nxt;
  logic        first_vco_r;
  logic        just_started_r;
  logic        window;
  logic        shot_start;
  logic        ref_may_open;
  logic        vco_may_open;
  logic        both_edges;
  logic        hit;
  logic        miss;
  logic [9:0]  hit_cnt_r;
  logic [9:0]  hit_cnt_nxt;
  logic        lock_nxt;
  logic        detect_on;

  assign detect_on = lkd_r.lock_detect_on;

  // which edge may open a window: lag opens on the reference,
  // lead opens on the vco, symmetric lets either open it
  assign ref_may_open = !lkd_r.asym_window_on
                      | !lkd_r.lead_window_sel;
  assign vco_may_open = !lkd_r.asym_window_on
                      |  lkd_r.lead_window_sel;
  assign both_edges   = ref_edge_i & vco_edge_i;

  // window opens on the first admissible edge while idle
  assign shot_start = detect_on && (win_r == WIN_IDLE) && !both_edges
                    && ((ref_edge_i && ref_may_open)
                     || (vco_edge_i && vco_may_open));

  lock_oneshot u_oneshot (
    .ref_clk_i   (ref_clk_i),
    .reset_i     (reset_i),
    .start_i     (shot_start),
    .ring_sel_i  (lkd_r.ring_oneshot_sel),
    .duration_i  (lkd_r.ring_duration),
    .trim_i      (lkd_r.ring_trim),
    .force_run_i (lkd_r.ring_force_run),
    .window_o    (window),
    .ring_tick_o (ring_tick_o)
  );

  // verdicts: coincident edges hit unless the window has just run out; a partner edge inside
  // the window hits; a repeat edge, a closed window or an edge
  // from the forbidden side misses
  always_comb begin
    win_nxt = win_r;
    hit     = 1'b0;
    miss    = 1'b0;
    if (!detect_on) begin
      win_nxt = WIN_IDLE;
    end else begin
      unique case (win_r)
        WIN_IDLE: begin
          if (both_edges) begin
            hit = 1'b1;
          end else if (shot_start) begin
            win_nxt = WIN_OPEN;
          end else if (ref_edge_i || vco_edge_i) begin
            miss = 1'b1;
          end
        end
        WIN_OPEN: begin
          if (first_vco_r ? ref_edge_i : vco_edge_i) begin
            hit     = window | just_started_r;
            miss    = !(window | just_started_r);
            win_nxt = WIN_IDLE;
          end else if (ref_edge_i || vco_edge_i) begin
            miss    = 1'b1;
            win_nxt = WIN_IDLE;
          end else if (!window && !just_started_r) begin
            miss    = 1'b1;
            win_nxt = WIN_IDLE;
          end
        end
      endcase
    end
  end

  // window tracker state
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      win_r          <= WIN_IDLE;
      first_vco_r    <= 1'b0;
      just_started_r <= 1'b0;
    end else begin
      win_r          <= win_nxt;
      just_started_r <= shot_start;
      if (shot_start) begin
        first_vco_r <= vco_edge_i;
      end
    end
  end

  // consecutive hit count saturates at 3ff, whatever the programmed target;
  // any miss starts the count over and drops lock
  assign hit_cnt_nxt = !detect_on ? 10'h000 :
                       miss       ? 10'h000 :
                       (hit && hit_cnt_r != 10'h3ff)
                                  ? hit_cnt_r + 10'h001 : hit_cnt_r;
  assign lock_nxt = detect_on && !miss
                 && (hit_cnt_nxt >= lkd_r.lock_count_max)
                 && (hit || lock_o);

  // lock flag and count
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      hit_cnt_r <= 10'h000;
      lock_o    <= 1'b0;
    end else begin
      hit_cnt_r <= hit_cnt_nxt;
      lock_o    <= lock_nxt;
    end
  end

  // ---------------------------------------------------------------
  // enables, feeds and pads
  // ---------------------------------------------------------------

  logic raw_feed_nxt;
  logic div_feed_nxt;
  logic pad_nxt;

  // power enables straight from the active copy; reserved bits and
  // the reference buffer are passed as software left them
  assign power_en_o        = en_r;
  assign slip_prevent_on_o = lkd_r.slip_prevent_on;

  // reference feeds gated per bit
  assign raw_feed_nxt = ref_in_i   & en_r.raw_ref_feed_on;
  assign div_feed_nxt = ref_edge_i & en_r.divided_ref_feed_on;

  // readback has priority on the shared pad over the lock flag
  assign pad_nxt = readback_active_i ? readback_data_i
                                     : (lock_o & lock_output_route_i);

  // feeds and pad data registered to keep them glitch free
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      raw_ref_feed_o      <= 1'b0;
      divided_ref_feed_o  <= 1'b0;
      lock_readback_pin_o <= 1'b0;
    end else begin
      raw_ref_feed_o      <= raw_feed_nxt;
      divided_ref_feed_o  <= div_feed_nxt;
      lock_readback_pin_o <= pad_nxt;
    end
  end

  // pad driver off leaves the pin floating, enable low drives it
  assign lock_readback_pin_oe_n_o = !en_r.readback_pad_on;

  // both general-purpose pads share one power enable
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_gpio
      always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
          gpio_pad_o[g] <= 1'b0;
        end else begin
          gpio_pad_o[g] <= gpo_data_i[g];
        end
      end
      assign gpio_pad_oe_n_o[g] = !en_r.gpio_pads_on;
    end
  endgenerate

  // divider enable kills the pulse, clock feed enable gates delivery
  logic div_clk_raw;

  vcodiv_stretch u_stretch (
    .ref_clk_i    (ref_clk_i),
    .reset_i      (reset_i),
    .div_pulse_i  (div_pulse_i),
    .div_on_i     (en_r.vcodiv_on),
    .stretch_on_i (en_r.duty_stretch_on),
    .ratio_i      (div_ratio_i),
    .div_clk_o    (div_clk_raw)
  );

  // delivery gate; the stretcher output is already a flop
  assign div_clk_o = div_clk_raw & en_r.vcodiv_digclk_on;

endmodule : lock_detect_and_enable_regs

// ### bench/lock_detect_and_enable_regs_asserts.sv
`timescale 1ns/1ps
`include "lock_detect_defines.svh"

module lock_detect_and_enable_regs_asserts
  import lock_detect_pkg::*;
(
  input wire logic                ref_clk_i,
  input wire logic                reset_i,
  input wire logic [`ADDR_W-1:0]  rd_addr_i,
  input wire logic [`DATA_W-1:0]  rd_data_o,
  input wire logic                ref_edge_i,
  input wire logic                vco_edge_i,
  input wire logic                ref_in_i,
  input wire logic                div_pulse_i,
  input wire logic [`RATIO_W-1:0] div_ratio_i,
  input wire logic                lock_o,
  input wire en_cfg_s             power_en_o,
  input wire logic                slip_prevent_on_o,
  input wire logic                raw_ref_feed_o,
  input wire logic                divided_ref_feed_o,
  input wire logic                div_clk_o,
  input wire logic                lock_readback_pin_oe_n_o,
  input wire logic [1:0]          gpio_pad_oe_n_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  // divider path is live only with both divider enables
  wire div_live = power_en_o.vcodiv_on && power_en_o.vcodiv_digclk_on;
  wire stretch  = power_en_o.duty_stretch_on && (div_ratio_i > 32);

  // pad drivers follow the active enables, low means driven
  gpio_oe_a : assert property (
    gpio_pad_oe_n_o == {2{!power_en_o.gpio_pads_on}})
    else $error("gpio pad enable wrong");
  readback_oe_a : assert property (
    lock_readback_pin_oe_n_o == !power_en_o.readback_pad_on)
    else $error("readback pad enable wrong");
  // feeds lag by one cycle; skip the edge right after reset
  raw_feed_a : assert property (
    !$past(reset_i) |->
      raw_ref_feed_o == $past(ref_in_i && power_en_o.raw_ref_feed_on))
    else $error("raw reference feed wrong");
  div_feed_a : assert property (
    !$past(reset_i) |-> divided_ref_feed_o ==
      $past(ref_edge_i && power_en_o.divided_ref_feed_on))
    else $error("divided reference feed wrong");
  // settings take effect only on a reference edge
  active_at_edge_a : assert property (
    $changed(power_en_o) || $changed(slip_prevent_on_o) |->
      $past(ref_edge_i))
    else $error("active copy moved without reference edge");
  digclk_gate_a : assert property (
    !power_en_o.vcodiv_digclk_on |-> !div_clk_o)
    else $error("divider clock passed while gated");
  div_single_a : assert property (
    div_pulse_i && !ref_edge_i && div_live && !stretch
      |=> div_clk_o ##1 !div_clk_o)
    else $error("divider pulse not one cycle");
  div_stretch_a : assert property (
    div_pulse_i && !ref_edge_i && div_live && stretch
      |=> div_clk_o [*4] ##1 !div_clk_o)
    else $error("divider pulse not stretched");
  lock_rise_a : assert property (
    $rose(lock_o) |-> $past(ref_edge_i || vco_edge_i))
    else $error("lock rose without phase edge");
  unmapped_rd_a : assert property (
    rd_addr_i != 6'h07 && rd_addr_i != 6'h08 |=> rd_data_o == 24'h00_0000)
    else $error("unmapped read not zero");
endmodule : lock_detect_and_enable_regs_asserts

bind lock_detect_and_enable_regs lock_detect_and_enable_regs_asserts u_chk (.*);

// ### bench/lock_detect_and_enable_regs_tb_top.sv
`timescale 1ns/1ps
`include "lock_detect_defines.svh"

module lock_detect_and_enable_regs_tb_top
  import lock_detect_pkg::*;
;
  logic                ref_clk_i, reset_i, wr_stb_i, ref_edge_i, vco_edge_i;
  logic                ref_in_i, div_pulse_i, lock_output_route_i;
  logic                readback_active_i, readback_data_i, lock_o;
  logic                ring_tick_o, slip_prevent_on_o, raw_ref_feed_o;
  logic                divided_ref_feed_o, div_clk_o, lock_readback_pin_o;
  logic                lock_readback_pin_oe_n_o, pin_exp;
  logic [`ADDR_W-1:0]  wr_addr_i, rd_addr_i;
  logic [`DATA_W-1:0]  wr_data_i, rd_data_o;
  logic [`RATIO_W-1:0] div_ratio_i;
  logic [1:0]          gpo_data_i, gpio_pad_o, gpio_pad_oe_n_o;
  en_cfg_s             power_en_o;
  int                  num_errors, num_checks, seed, w, e;
  int                  wr07, wr08, act07, act08;
  int                  stv[5] = '{0, 1, 1, 1, 1};
  int                  nv[5] = '{40, 32, 33, 33, 33};
  int                  dgv[5] = '{1, 1, 1, 0, 1};
  int                  dvv[5] = '{1, 1, 1, 1, 0};

  lock_detect_and_enable_regs dut_u (.*);

  // free running 100 MHz clock
  initial begin
    ref_clk_i = 0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic check(string name, logic [23:0] seen, logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done

  task automatic tick(int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : tick

  // one completed serial write; model keeps the written copies
  task automatic wr(logic [5:0] a, logic [23:0] d);
    wr_stb_i = 1;
    wr_addr_i = a;
    wr_data_i = d;
    tick(1);
    wr_stb_i = 0;
    if (a == 6'h07) wr07 = d & 24'h1f_ffff;
    if (a == 6'h08) wr08 = d & 24'h00_3fff;
  endtask : wr

  // phase detector edges; a reference edge loads the active copies
  // keep leaves the pulses up when another edge call follows at once
  task automatic edges(logic r, logic v, logic keep = 1'b0);
    ref_edge_i = r;
    vco_edge_i = v;
    tick(1);
    if (!keep) begin
      ref_edge_i = 0;
      vco_edge_i = 0;
    end
    if (r) begin
      act07 = wr07;
      act08 = wr08;
    end
  endtask : edges

  // write, apply at a reference edge, let any window run out
  task automatic wr_apply(logic [5:0] a, logic [23:0] d);
    wr(a, d);
    edges(1, 0);
    tick(6);
  endtask : wr_apply

  task automatic check_regs();
    rd_addr_i = 6'h07;
    tick(2);
    check("rd lock cfg", rd_data_o, 24'(wr07));
    rd_addr_i = 6'h08;
    tick(2);
    check("rd enables", rd_data_o, 24'(wr08));
    check("power_en", 24'(power_en_o), 24'(act08));
    check("slip", 24'(slip_prevent_on_o), 24'(act07[20]));
    check("gpio oe_n", 24'(gpio_pad_oe_n_o), {22'h0, {2{~act08[5]}}});
    check("pin oe_n", 24'(lock_readback_pin_oe_n_o), 24'(!act08[6]));
  endtask : check_regs

  task automatic lock_is(logic v);
    tick(3);
    check("lock", 24'(lock_o), 24'(v));
    check("pin lock", 24'(lock_readback_pin_o), 24'(v));
  endtask : lock_is

  // hang guard, well beyond the length of the sequence
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    num_errors++;
    test_done();
  end

  initial begin
    {wr_stb_i, ref_edge_i, vco_edge_i, ref_in_i, div_pulse_i} = '0;
    {lock_output_route_i, readback_active_i, readback_data_i} = '0;
    wr_addr_i = '0;
    wr_data_i = '0;
    rd_addr_i = '0;
    gpo_data_i = '0;
    div_ratio_i = 17'd40;
    seed = 22243;
    wr07 = 'h10_04fa;
    wr08 = 'h31ff;
    act07 = wr07;
    act08 = wr08;
    reset_i = 1;
    repeat (5) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    reset_i = 0;
    check_regs();
    // unmapped place reads zero and ignores writes
    rd_addr_i = 6'h15;
    tick(2);
    check("rd unmapped", rd_data_o, 24'h00_0000);
    wr(6'h15, 24'hff_ffff);
    check_regs();
    // random enables: written copy at once, active copy at ref edge
    repeat (4) begin
      wr(6'h08, ($random(seed) & 24'h00_35ff) | 24'h00_0008);
      check_regs();
      edges(1, 0);
      tick(1);
      check_regs();
      lock_output_route_i = 1;
      repeat (4) begin
        ref_in_i = 1'($random(seed));
        gpo_data_i = 2'($random(seed));
        readback_active_i = 1'($random(seed));
        readback_data_i = 1'($random(seed));
        // lock stays low here: the default count is never reached
        pin_exp = readback_active_i ? readback_data_i : 1'b0;
        tick(1);
        check("raw feed", 24'(raw_ref_feed_o), 24'(ref_in_i & act08[12]));
        check("gpio data", 24'(gpio_pad_o), 24'(gpo_data_i));
        check("pin data", 24'(lock_readback_pin_o), 24'(pin_exp));
      end
      edges(1, 0);
      check("div feed", 24'(divided_ref_feed_o), 24'(act08[13]));
      tick(3);
    end
    // divider output width across stretch mode, ratio and clock gate
    for (int i = 0; i < 5; i++) begin
      wr_apply(6'h08, 24'(32'h0000_307f | (dvv[i] << 8) | (stv[i] << 10)
                          | (dgv[i] << 7)));
      div_ratio_i = 17'(nv[i]);
      div_pulse_i = 1;
      tick(1);
      div_pulse_i = 0;
      w = 0;
      repeat (6) begin
        if (div_clk_o === 1'b1) w++;
        tick(1);
      end
      e = (dgv[i] && dvv[i])
        ? ((stv[i] && nv[i] > `DUTY_RATIO_MIN) ? `STRETCH_CYC : 1) : 0;
      check("div width", 24'(w), 24'(e));
    end
    // shared pad now carries the lock flag for the lock checks
    readback_active_i = 0;
    wr_apply(6'h08, 24'h00_31ff);
    // symmetric analog window, count of three hits
    wr_apply(6'h07, 24'h00_0403);
    check_regs();
    for (int i = 1; i <= 4; i++) begin
      edges(1, 1);
      lock_is(i >= 3);
    end
    edges(1, 0, 1);
    edges(1, 0);
    lock_is(0);
    // lead window: a lone reference edge misses, vco first hits
    wr_apply(6'h07, 24'h00_1c00);
    edges(1, 0);
    lock_is(0);
    edges(0, 1, 1);
    edges(1, 0);
    lock_is(1);
    // lag window: a lone vco edge misses, reference first hits
    wr_apply(6'h07, 24'h00_0c00);
    edges(0, 1);
    lock_is(0);
    edges(1, 0, 1);
    edges(0, 1);
    lock_is(1);
    // detector off drops lock
    wr_apply(6'h07, 24'h00_0000);
    lock_is(0);
    check_regs();
    // partner three cycles late: out of analog window, in ring window
    wr_apply(6'h07, 24'h00_0400);
    edges(1, 0);
    tick(2);
    edges(0, 1);
    lock_is(0);
    wr_apply(6'h07, 24'h02_6400);
    edges(1, 0);
    tick(2);
    edges(0, 1);
    lock_is(1);
    // forced ring: ticks in eight cycles follow the trim setting
    for (int t = 0; t < 4; t += 3) begin
      wr_apply(6'h07, 24'(32'h0008_0000 | (t << 17)));
      w = 0;
      repeat (8) begin
        if (ring_tick_o === 1'b1) w++;
        tick(1);
      end
      check("ring ticks", 24'(w), 24'(8 / (t + 1)));
    end
    test_done();
  end
endmodule : lock_detect_and_enable_regs_tb_top
